// File: dcff_pkg.sv
package dcff_pkg;
    localparam int DATA_W = 18;
    localparam int DEPTH = 64;
    localparam int IDX_W = 6;
    localparam int PTR_W = 7;
    localparam int ADDR_W = 8;
    localparam int INT_W = 6;

    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_AE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_AF_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h14;

    localparam logic [PTR_W-1:0] AE_OFS_RST = 7'h08;
    localparam logic [PTR_W-1:0] AF_OFS_RST = 7'h08;
    localparam logic [INT_W-1:0] INT_MASK_RST = 6'h00;
    localparam logic [1:0] PIN_SYNC_RST = 2'h1;

    localparam int CTRL_RETX = 0;
    localparam int SB_COUNT = 0;
    localparam int SB_EMPTY = 8;
    localparam int SB_AEMPTY = 9;
    localparam int SB_AFULL = 10;
    localparam int SB_FULL = 11;
    localparam int SB_SYNC = 12;
    localparam int SB_RECOV = 13;

    localparam int INT_FULL = 0;
    localparam int INT_EMPTY = 1;
    localparam int INT_AFULL = 2;
    localparam int INT_AEMPTY = 3;
    localparam int INT_OVER = 4;
    localparam int INT_UNDER = 5;

    localparam int CLK_NS = 10;
    localparam int RTR_NS = 12;
    localparam int RTR_CYC = (RTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RTR_LOAD = 2'(RTR_CYC - 1);

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_RECOVER = 1'b1
    } dcff_state_e;
endpackage

// File: dcff_fifo.sv
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module dcff_fifo (
    input wire logic clk,
    input wire logic rst,
    input wire logic write_req,
    input wire logic [dcff_pkg::DATA_W-1:0] din,
    input wire logic read_req,
    input wire logic oe_n,
    input wire logic sync_flag_select,
    output logic [dcff_pkg::DATA_W-1:0] q,
    output logic q_oe,
    output logic full_flag_n,
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic write_expansion_out,
    output logic read_expansion_out,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcff_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import dcff_pkg::*;

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    function automatic logic ae_low(input logic [PTR_W-1:0] cnt, input logic [PTR_W-1:0] ofs);
        return cnt < ofs;
    endfunction

    function automatic logic af_low(input logic [PTR_W-1:0] cnt, input logic [PTR_W-1:0] ofs);
        return ({1'b0, cnt} + {1'b0, ofs}) >= 8'(DEPTH + 1);
    endfunction

    logic apb_wr;

    function automatic logic reg_write(input logic [ADDR_W-1:0] a);
        return apb_wr && (paddr == a);
    endfunction

    // Pin synchronisers: oe_n in bit 0, flag select in bit 1
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= PIN_SYNC_RST;
            pin_s2 <= PIN_SYNC_RST;
        end else begin
            pin_s1 <= {sync_flag_select, oe_n};
            pin_s2 <= pin_s1;
        end
    end

    logic oe_n_s;
    logic async_mode;
    assign oe_n_s = pin_s2[0];
    assign async_mode = pin_s2[1];

    // Storage, no reset so it maps onto plain RAM
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] head_word;

    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W-1:0] count;
    logic [PTR_W-1:0] next_wptr;
    logic [PTR_W-1:0] next_rptr;
    logic [PTR_W-1:0] next_count;
    logic [1:0] rtr_cnt;
    logic [1:0] next_rtr_cnt;
    dcff_state_e state;
    dcff_state_e next_state;
    logic [DATA_W-1:0] next_q;
    logic next_q_oe;
    logic wr_ok;
    logic rd_ok;
    logic retx_go;

    logic [PTR_W-1:0] ae_ofs;
    logic [PTR_W-1:0] af_ofs;
    logic [PTR_W-1:0] next_ae_ofs;
    logic [PTR_W-1:0] next_af_ofs;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] next_int_stat;
    logic [INT_W-1:0] next_int_mask;
    logic [INT_W-1:0] int_ev;
    logic [INT_W-1:0] int_clr;

    assign count = wptr - rptr;
    assign head_word = mem[rptr[IDX_W-1:0]];
    assign apb_wr = psel & penable & pready & pwrite;

    always_comb begin
        retx_go = reg_write(REG_CTRL) & pwdata[CTRL_RETX];
        wr_ok = write_req & (count != PTR_W'(DEPTH));
        // Retransmit owns the read pointer in its cycle and during recovery
        rd_ok = read_req & (count != '0) & (state == ST_RUN) & ~retx_go;
        next_wptr = wr_ok ? wptr + PTR_W'(1) : wptr;
        next_rptr = rptr;
        if (retx_go) begin
            // Rewind to location 0; valid only up to one depth written since reset
            next_rptr = '0;
        end else if (rd_ok) begin
            next_rptr = rptr + PTR_W'(1);
        end
        next_count = next_wptr - next_rptr;
        next_state = state;
        next_rtr_cnt = rtr_cnt;
        case (state)
            ST_RUN: begin
                next_rtr_cnt = 2'h0;
            end
            ST_RECOVER: begin
                if (rtr_cnt == 2'h0) begin
                    next_state = ST_RUN;
                end else begin
                    next_rtr_cnt = rtr_cnt - 2'h1;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (retx_go) begin
            next_state = ST_RECOVER;
            next_rtr_cnt = RTR_LOAD;
        end
        next_q = rd_ok ? head_word : q;
        next_q_oe = ~oe_n_s;
    end

    always_ff @(posedge clk) begin
        if (wr_ok) begin
            mem[wptr[IDX_W-1:0]] <= din;
        end
    end

    // Clocks may run during reset; every flop loads a constant here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            state <= ST_RUN;
            rtr_cnt <= 2'h0;
            q <= '0;
            q_oe <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            state <= next_state;
            rtr_cnt <= next_rtr_cnt;
            q <= next_q;
            q_oe <= next_q_oe;
        end
    end

    // Flags, expansion pulses and interrupt
    logic next_full_n;
    logic next_empty_n;
    logic next_ae_n;
    logic next_af_n;
    logic next_wxo;
    logic next_rxo;
    logic next_irq;

    always_comb begin
        // Full and empty always track the edge that moves the pointers
        next_full_n = next_count != PTR_W'(DEPTH);
        next_empty_n = next_count != '0;
        if (async_mode) begin
            next_ae_n = ~ae_low(next_count, ae_ofs);
            next_af_n = ~af_low(next_count, af_ofs);
        end else begin
            // One extra edge of latency, as with a skew shorter than the minimum
            next_ae_n = ~ae_low(count, ae_ofs);
            next_af_n = ~af_low(count, af_ofs);
        end
        next_wxo = wr_ok & (wptr[IDX_W-1:0] == IDX_W'(DEPTH - 1));
        next_rxo = rd_ok & (rptr[IDX_W-1:0] == IDX_W'(DEPTH - 1));
        int_ev = '0;
        int_ev[INT_FULL] = full_flag_n & ~next_full_n;
        int_ev[INT_EMPTY] = empty_flag_n & ~next_empty_n;
        int_ev[INT_AFULL] = almost_full_flag_n & ~next_af_n;
        int_ev[INT_AEMPTY] = almost_empty_flag_n & ~next_ae_n;
        int_ev[INT_OVER] = write_req & ~wr_ok;
        int_ev[INT_UNDER] = read_req & (count == '0);
        int_clr = reg_write(REG_INT_STAT) ? pwdata[INT_W-1:0] : '0;
        // Set beats clear so an event in the clear cycle survives
        next_int_stat = (int_stat & ~int_clr) | int_ev;
        next_irq = |(next_int_stat & next_int_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            full_flag_n <= 1'b1;
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
            almost_full_flag_n <= 1'b1;
            write_expansion_out <= 1'b0;
            read_expansion_out <= 1'b0;
            int_stat <= '0;
            irq <= 1'b0;
        end else begin
            full_flag_n <= next_full_n;
            empty_flag_n <= next_empty_n;
            almost_empty_flag_n <= next_ae_n;
            almost_full_flag_n <= next_af_n;
            write_expansion_out <= next_wxo;
            read_expansion_out <= next_rxo;
            int_stat <= next_int_stat;
            irq <= next_irq;
        end
    end

    // APB slave: one wait state, answer registered
    logic [31:0] rd_mux;
    logic hit;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    always_comb begin
        rd_mux = 32'h0;
        hit = 1'b1;
        case (paddr)
            REG_CTRL: begin
                rd_mux = 32'h0;
            end
            REG_AE_OFS: begin
                rd_mux[PTR_W-1:0] = ae_ofs;
            end
            REG_AF_OFS: begin
                rd_mux[PTR_W-1:0] = af_ofs;
            end
            REG_STATUS: begin
                rd_mux[SB_COUNT +: PTR_W] = count;
                rd_mux[SB_EMPTY] = ~empty_flag_n;
                rd_mux[SB_AEMPTY] = ~almost_empty_flag_n;
                rd_mux[SB_AFULL] = ~almost_full_flag_n;
                rd_mux[SB_FULL] = ~full_flag_n;
                rd_mux[SB_SYNC] = ~async_mode;
                rd_mux[SB_RECOV] = state == ST_RECOVER;
            end
            REG_INT_STAT: begin
                rd_mux[INT_W-1:0] = int_stat;
            end
            REG_INT_MASK: begin
                rd_mux[INT_W-1:0] = int_mask;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        next_pready = psel & penable & ~pready;
        next_prdata = 32'h0;
        next_pslverr = 1'b0;
        if (next_pready) begin
            next_prdata = pwrite ? 32'h0 : rd_mux;
            next_pslverr = ~hit;
        end
        next_ae_ofs = reg_write(REG_AE_OFS) ? pwdata[PTR_W-1:0] : ae_ofs;
        next_af_ofs = reg_write(REG_AF_OFS) ? pwdata[PTR_W-1:0] : af_ofs;
        next_int_mask = reg_write(REG_INT_MASK) ? pwdata[INT_W-1:0] : int_mask;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ae_ofs <= AE_OFS_RST;
            af_ofs <= AF_OFS_RST;
            int_mask <= INT_MASK_RST;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ae_ofs <= next_ae_ofs;
            af_ofs <= next_af_ofs;
            int_mask <= next_int_mask;
        end
    end

    a_full_clears_on_read: assert property (
        (rd_ok && !wr_ok && !full_flag_n) |=> full_flag_n)
        else $error("full flag did not clear after read");

    a_empty_clears_on_write: assert property (
        (wr_ok && !empty_flag_n) |=> empty_flag_n)
        else $error("empty flag did not clear after write");

    a_reset_outcome: assert property (
        $past(rst) |-> (q == '0 && !empty_flag_n && full_flag_n && !q_oe))
        else $error("state after reset wrong");

    a_oe_three_state: assert property (
        oe_n_s |=> !q_oe)
        else $error("data bus driven while disabled");

    a_first_word_latency: assert property (
        (count == '0 && wr_ok) ##1 (read_req && state == ST_RUN && !retx_go)
        |=> q == $past(din, 2))
        else $error("first word late or wrong");

    a_read_data_word: assert property (
        rd_ok |=> q == $past(head_word))
        else $error("read word not presented");

    a_ae_sync_level: assert property (
        !$past(async_mode) |-> almost_empty_flag_n == ($past(count) >= $past(ae_ofs)))
        else $error("registered almost-empty level wrong");

    a_af_sync_level: assert property (
        !$past(async_mode) |-> almost_full_flag_n
        == (({1'b0, $past(count)} + {1'b0, $past(af_ofs)}) < 8'(DEPTH + 1)))
        else $error("registered almost-full level wrong");

    a_flag_async_level: assert property (
        $past(async_mode) |-> (almost_empty_flag_n == (count >= $past(ae_ofs)))
        && (almost_full_flag_n == (({1'b0, count} + {1'b0, $past(af_ofs)}) < 8'(DEPTH + 1))))
        else $error("immediate flag level wrong");

    a_wxo_pulse: assert property (
        write_expansion_out |-> $past(wr_ok) && $past(wptr[IDX_W-1:0]) == IDX_W'(DEPTH - 1))
        else $error("write expansion pulse wrong");

    a_rxo_pulse: assert property (
        (rd_ok && rptr[IDX_W-1:0] == IDX_W'(DEPTH - 1)) |=> read_expansion_out)
        else $error("read expansion pulse missing");

    a_ignore_full_write: assert property (
        (write_req && !full_flag_n) |=> $stable(wptr))
        else $error("write taken while full");

    a_retx_recovery: assert property (
        retx_go |=> (rptr == '0 && state == ST_RECOVER) ##[1:4] (state == ST_RUN))
        else $error("retransmit recovery too long");

    a_set_beats_clear: assert property (
        (int_ev & int_clr) != '0 |=> (int_stat & $past(int_ev)) == $past(int_ev))
        else $error("event lost under clear");

    c_fill_to_full: cover property (wr_ok && count == PTR_W'(DEPTH - 1));
    c_retransmit: cover property (retx_go ##[1:4] rd_ok);
    c_empty_to_read: cover property ($rose(empty_flag_n) ##1 rd_ok);
    c_write_wrap: cover property (write_expansion_out);
endmodule

// File: dcff_partner.sv
`timescale 1ns/100ps
module dcff_partner (
    input wire logic clk,
    input wire logic [dcff_pkg::DATA_W-1:0] q,
    output logic write_req,
    output logic [dcff_pkg::DATA_W-1:0] din,
    output logic read_req
);
    import dcff_pkg::*;
    logic [DATA_W-1:0] tx[$];
    logic [DATA_W-1:0] rx[$];
    initial begin
        write_req = 1'b0;
        read_req = 1'b0;
        din = '0;
    end
    // Back to back writes, request held across each taking edge
    task automatic send();
        while (tx.size() > 0) begin
            @(posedge clk);
            write_req <= 1'b1;
            din <= tx.pop_front();
        end
        @(posedge clk);
        write_req <= 1'b0;
        // Released bus must not keep showing the last word
        din <= ~din;
    endtask
    // Word of the read taken at one edge is seen at the next
    task automatic fetch(input int n);
        for (int i = 0; i <= n + 1; i++) begin
            @(posedge clk);
            if (i >= 2) begin
                rx.push_back(q);
            end
            read_req <= (i < n);
        end
    endtask
endmodule

// File: test_dual_clock_fifo_flag_timing.sv
`timescale 1ns/100ps
module test_dual_clock_fifo_flag_timing;
    import dcff_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic oe_n = 1'b0;
    logic sync_flag_select = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic write_req, read_req, q_oe, full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n;
    logic write_expansion_out, read_expansion_out, irq, pready, pslverr, err;
    logic [DATA_W-1:0] din, q;
    logic [31:0] prdata, rd;
    logic [DATA_W-1:0] model[$];
    logic [DATA_W-1:0] hist[$];
    int seed = 5515;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int wxo_seen = 0;
    int rxo_seen = 0;

    always #5 clk = ~clk;

    dcff_fifo dut (
        .clk(clk), .rst(rst), .write_req(write_req), .din(din), .read_req(read_req),
        .oe_n(oe_n), .sync_flag_select(sync_flag_select), .q(q), .q_oe(q_oe),
        .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .write_expansion_out(write_expansion_out), .read_expansion_out(read_expansion_out),
        .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    dcff_partner wr (
        .clk(clk), .q(q), .write_req(write_req), .din(din), .read_req(read_req)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (write_expansion_out === 1'b1) begin
            wxo_seen++;
        end
        if (read_expansion_out === 1'b1) begin
            rxo_seen++;
        end
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic flags(input logic e, input logic f, input logic ae, input logic af);
        chk("empty_flag_n", {31'h0, e}, {31'h0, empty_flag_n});
        chk("full_flag_n", {31'h0, f}, {31'h0, full_flag_n});
        chk("almost_empty_flag_n", {31'h0, ae}, {31'h0, almost_empty_flag_n});
        chk("almost_full_flag_n", {31'h0, af}, {31'h0, almost_full_flag_n});
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic push(input int n, input bit keep);
        logic [DATA_W-1:0] w;
        repeat (n) begin
            w = DATA_W'($random(seed));
            if (keep) begin
                model.push_back(w);
                hist.push_back(w);
            end
            wr.tx.push_back(w);
        end
        wr.send();
    endtask

    task automatic pull(input int n);
        wr.fetch(n);
        while (wr.rx.size() > 0) begin
            chk("q", 32'(model.pop_front()), 32'(wr.rx.pop_front()));
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        chk("q in reset", 32'h0, 32'(q));
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("q_oe", 32'h1, {31'h0, q_oe});
        chk("q", 32'h0, 32'(q));
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        oe_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("q_oe", 32'h0, {31'h0, q_oe});
        oe_n <= 1'b0;
        $display("test reset done");
        wr.fetch(1);
        wr.rx.delete();
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        push(8, 1'b1);
        @(posedge clk);
        chk("empty_flag_n", 32'h1, {31'h0, empty_flag_n});
        chk("almost_empty_flag_n", 32'h0, {31'h0, almost_empty_flag_n});
        @(posedge clk);
        chk("almost_empty_flag_n", 32'h1, {31'h0, almost_empty_flag_n});
        push(48, 1'b1);
        repeat (2) @(posedge clk);
        flags(1'b1, 1'b1, 1'b1, 1'b1);
        push(1, 1'b1);
        repeat (2) @(posedge clk);
        flags(1'b1, 1'b1, 1'b1, 1'b0);
        push(7, 1'b1);
        repeat (2) @(posedge clk);
        flags(1'b1, 1'b0, 1'b1, 1'b0);
        chk("wxo pulses", 32'h1, 32'(wxo_seen));
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h1C40, rd);
        push(1, 1'b0);
        repeat (2) @(posedge clk);
        flags(1'b1, 1'b0, 1'b1, 1'b0);
        $display("test fill done");
        pull(1);
        chk("full_flag_n", 32'h1, {31'h0, full_flag_n});
        pull(55);
        @(posedge clk);
        flags(1'b1, 1'b1, 1'b1, 1'b1);
        pull(1);
        @(posedge clk);
        flags(1'b1, 1'b1, 1'b0, 1'b1);
        pull(7);
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        // The last read's pulse is counted at this edge, so look one edge later
        @(posedge clk);
        chk("rxo pulses", 32'h1, 32'(rxo_seen));
        $display("test drain done");
        apb(1'b0, REG_INT_STAT, 32'h0);
        chk("int_stat", 32'h3F, rd);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, REG_INT_MASK, 32'h10);
        @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, REG_INT_STAT, 32'h10);
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b0, REG_INT_STAT, 32'h0);
        chk("int_stat", 32'h2F, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b0, REG_AE_OFS, 32'h0);
        chk("ae offset", 32'h8, rd);
        $display("test registers done");
        sync_flag_select <= 1'b1;
        repeat (4) @(posedge clk);
        push(8, 1'b1);
        @(posedge clk);
        flags(1'b1, 1'b1, 1'b1, 1'b1);
        pull(8);
        $display("test immediate mode done");
        // Second reset in mid run, back to registered flags
        rst <= 1'b1;
        sync_flag_select <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        model.delete();
        hist.delete();
        @(posedge clk);
        chk("q_oe", 32'h0, {31'h0, q_oe});
        chk("q", 32'h0, 32'(q));
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        // Read in the cycle right after the first write at the empty boundary
        fork
            push(2, 1'b1);
            begin
                @(posedge clk);
                pull(2);
            end
        join
        // Underflow in the very cycle that software clears it
        fork
            apb(1'b1, REG_INT_STAT, 32'h20);
            wr.fetch(3);
        join
        wr.rx.delete();
        apb(1'b0, REG_INT_STAT, 32'h0);
        chk("int_stat", 32'h22, rd);
        $display("test second reset done");
        apb(1'b1, REG_AE_OFS, 32'h2);
        apb(1'b1, REG_AF_OFS, 32'h3F);
        apb(1'b1, REG_CTRL, 32'h1);
        model = hist;
        // Two recovery cycles, then one more edge so registered flags catch up
        repeat (3) @(posedge clk);
        flags(1'b1, 1'b1, 1'b1, 1'b0);
        pull(2);
        $display("test retransmit done");
        complete_run();
    end
endmodule
